// ==== hw/rca_pkg.sv ====
// constants and types for the alarm configuration and repeat block
package rca_pkg;
  typedef logic [3:0]  rca_addr_t;
  typedef logic [15:0] rca_word_t;

  // register byte offsets
  localparam rca_addr_t OFS_CONFIG   = 4'h0;
  localparam rca_addr_t OFS_WINDOW   = 4'h4;
  localparam rca_addr_t OFS_STATUS   = 4'h8;
  localparam rca_addr_t OFS_IRQ_MASK = 4'hC;

  // configuration field positions
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_REPEAT = 14;
  localparam int unsigned IVL_HI     = 13;
  localparam int unsigned IVL_LO     = 10;
  localparam int unsigned PTR_HI     = 9;
  localparam int unsigned PTR_LO     = 8;
  localparam int unsigned CNT_HI     = 7;
  localparam int unsigned CNT_LO     = 0;

  // status and mask bit positions
  localparam int unsigned STAT_W     = 2;
  localparam int unsigned STAT_EVENT = 0;
  localparam int unsigned STAT_LAST  = 1;

  // values after reset and counter limits
  localparam rca_word_t         WORD_RST   = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RST   = 2'h0;
  localparam logic [7:0]        CNT_ZERO   = 8'h00;
  localparam logic [7:0]        CNT_FULL   = 8'hFF;
  localparam logic [7:0]        CNT_ONE    = 8'h01;
  localparam logic [1:0]        PTR_FLOOR  = 2'h0;
  localparam logic [1:0]        PTR_ONE    = 2'h1;
  localparam logic [3:0]        IVL_RST    = 4'h0;
  localparam int unsigned       SLOTS      = 4;

  // value window slots
  localparam logic [1:0] SLOT_MIN_SEC   = 2'h0;
  localparam logic [1:0] SLOT_WDAY_HOUR = 2'h1;
  localparam logic [1:0] SLOT_MON_DAY   = 2'h2;

  // interval select codes
  localparam logic [3:0] IVL_HALF_SEC = 4'h0;
  localparam logic [3:0] IVL_TEN_SEC  = 4'h2;
  localparam logic [3:0] IVL_MINUTE   = 4'h3;
  localparam logic [3:0] IVL_TEN_MIN  = 4'h4;
  localparam logic [3:0] IVL_HOUR     = 4'h5;
  localparam logic [3:0] IVL_MONTH    = 4'h8;
  localparam logic [3:0] IVL_YEAR     = 4'h9;

  // current calendar time, bcd fields
  typedef struct packed {
    logic       half;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
  } rca_time_s;
endpackage : rca_pkg

// ==== hw/rca_if.sv ====
// carrier between the alarm control and the time comparator
`timescale 1ns/1ps
interface rca_if;
  import rca_pkg::*;
  rca_time_s  now;
  logic       tick;
  rca_word_t  min_sec;
  rca_word_t  wday_hour;
  rca_word_t  mon_day;
  logic [3:0] interval;
  logic       hit;

  modport ctl (output now, tick, min_sec, wday_hour, mon_day, interval, input hit);
  modport cmp (input now, tick, min_sec, wday_hour, mon_day, interval, output hit);
endinterface : rca_if

// ==== hw/rca_match.sv ====
// time against alarm value comparator for the selected interval
`timescale 1ns/1ps
module rca_match (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rca_if.cmp        m
);
  import rca_pkg::*;

  logic sec_eq;
  logic sec_ones;
  logic min_eq;
  logic min_ones;
  logic hour_eq;
  logic day_eq;
  logic mon_eq;
  logic on_sec;
  logic hit_c;

  always_comb begin
    sec_eq   = m.now.sec == m.min_sec[7:0];
    sec_ones = m.now.sec[3:0] == m.min_sec[3:0];
    min_eq   = m.now.min == m.min_sec[15:8];
    min_ones = m.now.min[3:0] == m.min_sec[11:8];
    hour_eq  = m.now.hour == m.wday_hour[7:0];
    day_eq   = m.now.day == m.mon_day[7:0];
    mon_eq   = m.now.month == m.mon_day[15:8];
    on_sec   = !m.now.half;
    // compared fields follow the interval code
    case (m.interval)
      IVL_HALF_SEC: hit_c = 1'b1;
      IVL_TEN_SEC:  hit_c = on_sec && sec_ones;
      IVL_MINUTE:   hit_c = on_sec && sec_eq;
      IVL_TEN_MIN:  hit_c = on_sec && sec_eq && min_ones;
      IVL_HOUR:     hit_c = on_sec && sec_eq && min_eq;
      // a feb 29 alarm only meets a real date in leap years
      IVL_MONTH:    hit_c = on_sec && sec_eq && min_eq && hour_eq && day_eq;
      IVL_YEAR:     hit_c = on_sec && sec_eq && min_eq && hour_eq && day_eq && mon_eq;
      default:      hit_c = 1'b0;
    endcase
  end

  assign m.hit = m.tick && hit_c;

  a_reserved_silent: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (m.interval inside {4'h1, 4'h6, 4'h7, [4'hA:4'hF]}) |-> !m.hit)
    else $error("reserved interval code produced a match");

  a_half_every_tick: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (m.tick && m.interval == IVL_HALF_SEC) |-> m.hit)
    else $error("half second interval missed a tick");
endmodule : rca_match

// ==== hw/rca_top.sv ====
// alarm configuration and repeat control with register port
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Contract
// - config word: enable 15, repeat 14, interval 13:10, pointer 9:8, count 7:0.
// - after an event with count zero and repeat off, clear enable.
// - no alarm events while enable is low.
// - with repeat on, count wraps from 00 to FF on the next event.
// - with repeat off, count holds at 00 and never wraps.
// - every alarm event with a nonzero count decrements the repeat count by one.
// - with repeat off, count is the number of alarms after the next one; zero means no repeat.
// - codes 0000,0010,0011,0100,0101: half s, 10 s, minute, 10 min, hour.
// - code 1000 monthly, 1001 yearly; feb 29 yearly fires every four years.
// - pointer picks window slot, steps down per window access, stops at 00.
module rca_top (
  input  wire logic              REF_CLK_I,
  input  wire logic              RESET_I,
  input  wire rca_pkg::rca_addr_t ADDR_I,
  input  wire rca_pkg::rca_word_t WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output      rca_pkg::rca_word_t RDATA_O,
  input  wire logic              TICK_I,
  input  wire rca_pkg::rca_time_s TIME_I,
  output      logic              ALARM_O,
  output      logic              ENABLE_O,
  output      logic              IRQ_O
);
  import rca_pkg::*;

  rca_if link ();

  logic              alarm_enable;
  logic              repeat_on;
  logic [3:0]        alarm_interval_select;
  logic [1:0]        value_window_pointer;
  logic [7:0]        repeat_count;
  rca_word_t         alarm_value [SLOTS];
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] irq_mask;
  rca_word_t         rdata;
  logic              alarm;

  logic              cfg_wr;
  logic              win_wr;
  logic              win_rd;
  logic              win_acc;
  logic              stat_rd;
  logic              mask_wr;
  logic              event_now;
  logic              last_now;
  rca_word_t         config_word;
  rca_word_t         next_rdata;

  // bus decode
  assign cfg_wr  = WR_I && ADDR_I == OFS_CONFIG;
  assign win_wr  = WR_I && ADDR_I == OFS_WINDOW;
  assign win_rd  = RD_I && ADDR_I == OFS_WINDOW;
  assign win_acc = win_wr || win_rd;
  assign stat_rd = RD_I && ADDR_I == OFS_STATUS;
  assign mask_wr = WR_I && ADDR_I == OFS_IRQ_MASK;

  // comparator hookup
  assign link.now       = TIME_I;
  assign link.tick      = TICK_I;
  assign link.min_sec   = alarm_value[SLOT_MIN_SEC];
  assign link.wday_hour = alarm_value[SLOT_WDAY_HOUR];
  assign link.mon_day   = alarm_value[SLOT_MON_DAY];
  assign link.interval  = alarm_interval_select;

  rca_match u_match (
    .clk_i (REF_CLK_I),
    .rst_i (RESET_I),
    .m     (link)
  );

  // events only while enabled
  assign event_now = link.hit && alarm_enable;
  // zero count without repeat marks the final alarm
  assign last_now  = event_now && repeat_count == CNT_ZERO && !repeat_on;

  // field packing of the configuration word
  assign config_word = {alarm_enable, repeat_on, alarm_interval_select,
                        value_window_pointer, repeat_count};

  // alarm enable
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      alarm_enable <= 1'b0;
    end else if (cfg_wr) begin
      alarm_enable <= WDATA_I[BIT_ENABLE];
    end else if (last_now) begin
      alarm_enable <= 1'b0;
    end
  end

  // repeat option and interval select
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      repeat_on             <= 1'b0;
      alarm_interval_select <= IVL_RST;
    end else if (cfg_wr) begin
      repeat_on             <= WDATA_I[BIT_REPEAT];
      alarm_interval_select <= WDATA_I[IVL_HI:IVL_LO];
    end
  end

  // repeat counter
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      repeat_count <= CNT_ZERO;
    end else if (cfg_wr) begin
      repeat_count <= WDATA_I[CNT_HI:CNT_LO];
    end else if (event_now) begin
      if (repeat_count != CNT_ZERO) begin
        repeat_count <= repeat_count - CNT_ONE;
      end else if (repeat_on) begin
        repeat_count <= CNT_FULL;
      end else begin
        repeat_count <= CNT_ZERO;
      end
    end
  end

  // value window pointer
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      value_window_pointer <= PTR_FLOOR;
    end else if (cfg_wr) begin
      value_window_pointer <= WDATA_I[PTR_HI:PTR_LO];
    end else if (win_acc && value_window_pointer != PTR_FLOOR) begin
      value_window_pointer <= value_window_pointer - PTR_ONE;
    end
  end

  // alarm value slots behind the window
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < SLOTS; i++) begin
        alarm_value[i] <= WORD_RST;
      end
    end else if (win_wr) begin
      alarm_value[value_window_pointer] <= WDATA_I;
    end
  end

  // sticky status, set beats read clear
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      status <= STAT_RST;
    end else begin
      status[STAT_EVENT] <= event_now || (status[STAT_EVENT] && !stat_rd);
      status[STAT_LAST]  <= last_now || (status[STAT_LAST] && !stat_rd);
    end
  end

  // interrupt mask
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      irq_mask <= STAT_RST;
    end else if (mask_wr) begin
      irq_mask <= WDATA_I[STAT_W-1:0];
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    next_rdata = WORD_RST;
    if (RD_I) begin
      case (ADDR_I)
        OFS_CONFIG:   next_rdata = config_word;
        OFS_WINDOW:   next_rdata = alarm_value[value_window_pointer];
        OFS_STATUS:   next_rdata = {{(16 - STAT_W){1'b0}}, status};
        OFS_IRQ_MASK: next_rdata = {{(16 - STAT_W){1'b0}}, irq_mask};
        default:      next_rdata = WORD_RST;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rdata <= WORD_RST;
    end else begin
      rdata <= next_rdata;
    end
  end

  // alarm pulse
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      alarm <= 1'b0;
    end else begin
      alarm <= event_now;
    end
  end

  assign RDATA_O  = rdata;
  assign ALARM_O  = alarm;
  assign ENABLE_O = alarm_enable;
  assign IRQ_O    = |(status & irq_mask);

  a_enable_autoclear: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (event_now && repeat_count == CNT_ZERO && !repeat_on && !cfg_wr)
      |=> !alarm_enable && !ENABLE_O)
    else $error("enable not cleared after final alarm");

  a_enable_kept: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (alarm_enable && !cfg_wr && (repeat_count != CNT_ZERO || repeat_on))
      |=> alarm_enable)
    else $error("enable dropped while repeats remain");

  a_no_alarm_off: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    !alarm_enable |=> !ALARM_O)
    else $error("alarm pulse while disabled");

  a_count_wrap: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (event_now && repeat_on && repeat_count == CNT_ZERO && !cfg_wr)
      |=> repeat_count == CNT_FULL)
    else $error("count did not wrap under repeat");

  a_count_hold: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (!repeat_on && repeat_count == CNT_ZERO && !cfg_wr)
      |=> repeat_count == CNT_ZERO)
    else $error("count left zero without repeat");

  a_count_step: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (event_now && repeat_count != CNT_ZERO && !cfg_wr)
      |=> repeat_count == $past(repeat_count) - CNT_ONE)
    else $error("count not decremented on event");

  a_count_still: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (!event_now && !cfg_wr) |=> $stable(repeat_count))
    else $error("count moved without an event");

  a_ptr_step: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (win_acc && value_window_pointer != PTR_FLOOR)
      |=> value_window_pointer == $past(value_window_pointer) - PTR_ONE)
    else $error("pointer not stepped on window access");

  a_ptr_floor: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (win_acc && value_window_pointer == PTR_FLOOR) |=> value_window_pointer == PTR_FLOOR)
    else $error("pointer went below floor");

  a_window_read: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    win_rd |=> RDATA_O == $past(alarm_value[value_window_pointer]))
    else $error("window read returned wrong slot");

  a_config_fields: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    cfg_wr ##1 RD_I && ADDR_I == OFS_CONFIG && !event_now
      |=> RDATA_O == $past(WDATA_I, 2))
    else $error("config readback differs from written word");

  a_status_sticky: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    event_now |=> status[STAT_EVENT] && IRQ_O == irq_mask[STAT_EVENT] || status[STAT_LAST])
    else $error("event not recorded in status");

  a_alarm_pulse: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    event_now |=> ALARM_O)
    else $error("alarm pulse missing after event");

  a_alarm_needs_hit: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    !link.hit |=> !ALARM_O)
    else $error("alarm pulse without a time match");

  a_enable_write: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    cfg_wr |=> alarm_enable == $past(WDATA_I[BIT_ENABLE]))
    else $error("enable bit not taken from write");

  a_fields_write: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    cfg_wr |=> {repeat_on, alarm_interval_select, value_window_pointer, repeat_count}
      == $past(WDATA_I[BIT_REPEAT:CNT_LO]))
    else $error("config fields not taken from write");

  a_setup_still: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    !cfg_wr |=> $stable(alarm_interval_select) && $stable(repeat_on))
    else $error("interval or repeat option moved without a write");

  a_enable_no_set: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (!alarm_enable && !cfg_wr) |=> !alarm_enable)
    else $error("enable rose without a write");

  a_last_status: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    last_now |=> status[STAT_LAST])
    else $error("final alarm not recorded in status");

  a_event_status: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    event_now |=> status[STAT_EVENT])
    else $error("event bit not set after event");

  a_status_clear: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (stat_rd && !event_now) |=> !status[STAT_EVENT])
    else $error("status read did not clear event bit");

  a_status_kept: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (status[STAT_EVENT] && !stat_rd) |=> status[STAT_EVENT])
    else $error("event bit lost without a read");

  a_irq_quiet: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    status == STAT_RST |-> !IRQ_O)
    else $error("interrupt with empty status");

  a_irq_raise: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (status[STAT_EVENT] && irq_mask[STAT_EVENT]) |-> IRQ_O)
    else $error("unmasked event did not raise interrupt");

  a_ptr_idle: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (!win_acc && !cfg_wr) |=> $stable(value_window_pointer))
    else $error("pointer moved without window access");

  a_slots_idle: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    !win_wr |=> $stable(link.min_sec) && $stable(link.wday_hour) && $stable(link.mon_day))
    else $error("alarm value changed without window write");

  a_rdata_idle: assert property (
    @(posedge REF_CLK_I) disable iff (RESET_I)
    !RD_I |=> RDATA_O == WORD_RST)
    else $error("read data not zero outside a read");
endmodule : rca_top

// ==== dv/tb_top.sv ====
// self-checking bench for the alarm configuration and repeat block
`timescale 1ns/1ps
module tb_top;
  import rca_pkg::*;
  logic       REF_CLK_I;
  logic       RESET_I;
  rca_addr_t  ADDR_I;
  rca_word_t  WDATA_I;
  logic       WR_I;
  logic       RD_I;
  rca_word_t  RDATA_O;
  logic       TICK_I;
  rca_time_s  TIME_I;
  logic       ALARM_O;
  logic       ENABLE_O;
  logic       IRQ_O;
  int         n_fail;
  int         comparisons;
  int         cycles;
  rca_word_t  v;
  rca_word_t  w;
  rca_time_s  t;
  logic       al;
  logic       en;
  logic       rep;
  logic       fin;
  logic [7:0] cnt;
  logic [3:0] codes [12];

  rca_top dut (
    .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TICK_I(TICK_I), .TIME_I(TIME_I),
    .ALARM_O(ALARM_O), .ENABLE_O(ENABLE_O), .IRQ_O(IRQ_O)
  );

  initial begin
    REF_CLK_I = 1'b0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end

  // hang guard, runs need about 570 cycles
  always @(posedge REF_CLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  function automatic rca_word_t mk(input logic e, input logic r, input logic [3:0] i,
                                   input logic [1:0] p, input logic [7:0] c);
    return {e, r, i, p, c};
  endfunction : mk

  // expected match per interval code, slots hold feb 29 13:45:30
  function automatic logic exp_hit(input logic [3:0] c, input rca_time_s tm);
    logic s;
    logic m;
    logic d;
    s = !tm.half && tm.sec == 8'h30;
    m = s && tm.min == 8'h45;
    d = m && tm.hour == 8'h13 && tm.day == 8'h29;
    case (c)
      IVL_HALF_SEC: return 1'b1;
      IVL_TEN_SEC:  return !tm.half && tm.sec[3:0] == 4'h0;
      IVL_MINUTE:   return s;
      IVL_TEN_MIN:  return s && tm.min[3:0] == 4'h5;
      IVL_HOUR:     return m;
      IVL_MONTH:    return d;
      IVL_YEAR:     return d && tm.month == 8'h02;
      default:      return 1'b0;
    endcase
  endfunction : exp_hit

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input rca_addr_t a, input rca_word_t d);
    @(posedge REF_CLK_I);
    WR_I    <= 1'b1;
    ADDR_I  <= a;
    WDATA_I <= d;
    @(posedge REF_CLK_I);
    WR_I    <= 1'b0;
  endtask : wr

  task automatic rdr(input rca_addr_t a, output rca_word_t d);
    @(posedge REF_CLK_I);
    RD_I   <= 1'b1;
    ADDR_I <= a;
    @(posedge REF_CLK_I);
    RD_I   <= 1'b0;
    #1 d = RDATA_O;
  endtask : rdr

  // write then read with no gap between the strobes
  task automatic wrrd(input rca_addr_t a, input rca_word_t d, output rca_word_t q);
    @(posedge REF_CLK_I);
    WR_I    <= 1'b1;
    ADDR_I  <= a;
    WDATA_I <= d;
    @(posedge REF_CLK_I);
    WR_I    <= 1'b0;
    RD_I    <= 1'b1;
    @(posedge REF_CLK_I);
    RD_I    <= 1'b0;
    #1 q = RDATA_O;
  endtask : wrrd

  task automatic tick(input rca_time_s tm, output logic a);
    @(posedge REF_CLK_I);
    TICK_I <= 1'b1;
    TIME_I <= tm;
    @(posedge REF_CLK_I);
    TICK_I <= 1'b0;
    #1 a = ALARM_O;
  endtask : tick

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    RESET_I = 1'b1;
    WR_I    = 1'b0;
    RD_I    = 1'b0;
    ADDR_I  = '0;
    WDATA_I = '0;
    TICK_I  = 1'b0;
    TIME_I  = '0;
    codes   = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'h1, 4'h6, 4'h7, 4'hC, 4'hF};
    void'($urandom(32'hD5E47731));
    repeat (6) @(posedge REF_CLK_I);
    RESET_I <= 1'b0;
    rdr(OFS_CONFIG, v);
    chk(v, WORD_RST);
    rdr(OFS_STATUS, v);
    chk(v, 16'h0000);
    rdr(OFS_IRQ_MASK, v);
    chk(v, 16'h0000);
    chk({15'h0, ENABLE_O}, 16'h0000);
    done("reset");
    // random field values, legal interval codes only
    for (int k = 0; k < 8; k++) begin
      w = mk(1'b0, 1'($urandom), codes[$urandom % 7], 2'($urandom), 8'($urandom));
      wrrd(OFS_CONFIG, w, v);
      chk(v, w);
    end
    wr(4'h2, 16'hFFFF);
    rdr(4'h2, v);
    chk(v, 16'h0000);
    rdr(OFS_CONFIG, v);
    chk(v, w);
    done("fields");
    wr(OFS_CONFIG, mk(1'b0, 1'b0, IVL_RST, 2'h3, CNT_ZERO));
    for (int k = 3; k >= 0; k--) begin
      wr(OFS_WINDOW, 16'hA000 + 16'(k));
    end
    rdr(OFS_CONFIG, v);
    chk({14'h0, v[PTR_HI:PTR_LO]}, 16'h0000);
    wr(OFS_CONFIG, mk(1'b0, 1'b0, IVL_RST, 2'h3, CNT_ZERO));
    for (int k = 3; k >= -1; k--) begin
      rdr(OFS_WINDOW, v);
      chk(v, 16'hA000 + 16'((k < 0) ? 0 : k));
    end
    done("window");
    for (int c = 0; c < 6; c++) begin
      cnt = 8'(c % 3);
      rep = 1'(c / 3);
      en  = 1'b1;
      wr(OFS_CONFIG, mk(1'b1, rep, IVL_HALF_SEC, PTR_FLOOR, cnt));
      repeat (4) begin
        fin = en && cnt == 8'h00 && !rep;
        tick('0, al);
        chk({15'h0, al}, {15'h0, en});
        rdr(OFS_STATUS, v);
        chk(v, en ? {14'h0, fin, 1'b1} : 16'h0000);
        if (en) begin
          cnt = (cnt == 8'h00 && !rep) ? 8'h00 : cnt - 8'h01;
          en  = !fin;
        end
        rdr(OFS_CONFIG, v);
        chk(v, mk(en, rep, IVL_HALF_SEC, PTR_FLOOR, cnt));
        chk({15'h0, ENABLE_O}, {15'h0, en});
      end
    end
    done("repeat");
    wr(OFS_IRQ_MASK, 16'h0001);
    rdr(OFS_IRQ_MASK, v);
    chk(v, 16'h0001);
    wr(OFS_CONFIG, mk(1'b1, 1'b0, IVL_HALF_SEC, PTR_FLOOR, 8'h05));
    tick('0, al);
    chk({15'h0, IRQ_O}, 16'h0001);
    rdr(OFS_STATUS, v);
    chk(v, 16'h0001);
    chk({15'h0, IRQ_O}, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0002);
    tick('0, al);
    chk({15'h0, IRQ_O}, 16'h0000);
    rdr(OFS_STATUS, v);
    chk(v, 16'h0001);
    done("interrupt");
    t     = '0;
    t.sec = 8'h30;
    wr(OFS_CONFIG, mk(1'b0, 1'b0, IVL_RST, PTR_FLOOR, CNT_ZERO));
    wr(OFS_WINDOW, 16'h0030);
    for (int k = 7; k < 12; k++) begin
      wr(OFS_CONFIG, mk(1'b1, 1'b0, codes[k], PTR_FLOOR, 8'h05));
      tick(t, al);
      chk({15'h0, al}, 16'h0000);
    end
    wr(OFS_CONFIG, mk(1'b1, 1'b1, IVL_MINUTE, PTR_FLOOR, 8'h05));
    t.sec = 8'h31;
    tick(t, al);
    chk({15'h0, al}, 16'h0000);
    t.sec  = 8'h30;
    t.half = 1'b1;
    tick(t, al);
    chk({15'h0, al}, 16'h0000);
    t.half = 1'b0;
    tick(t, al);
    chk({15'h0, al}, 16'h0001);
    rdr(OFS_CONFIG, v);
    chk(v, mk(1'b1, 1'b1, IVL_MINUTE, PTR_FLOOR, 8'h04));
    done("interval");
    // every legal code against a full match, or with one field spoiled at random
    wr(OFS_CONFIG, mk(1'b0, 1'b0, IVL_RST, 2'h2, CNT_ZERO));
    wr(OFS_WINDOW, 16'h0229);
    wr(OFS_WINDOW, 16'h0013);
    wr(OFS_WINDOW, 16'h4530);
    for (int k = 0; k < 70; k++) begin
      t = {1'b0, 8'h30, 8'h45, 8'h13, 8'h29, 8'h02};
      case ($urandom % 7)
        1:       t.half  = 1'b1;
        2:       t.sec   = 8'($urandom);
        3:       t.min   = 8'($urandom);
        4:       t.hour  = 8'($urandom);
        5:       t.day   = 8'($urandom);
        6:       t.month = 8'($urandom);
        default: t.half  = 1'b0;
      endcase
      wr(OFS_CONFIG, mk(1'b1, 1'b1, codes[k % 7], PTR_FLOOR, CNT_FULL));
      tick(t, al);
      chk({15'h0, al}, {15'h0, exp_hit(codes[k % 7], t)});
    end
    done("codes");
    // reset in mid-run returns every register to zero
    @(posedge REF_CLK_I);
    RESET_I <= 1'b1;
    repeat (2) @(posedge REF_CLK_I);
    RESET_I <= 1'b0;
    @(posedge REF_CLK_I);
    rdr(OFS_CONFIG, v);
    chk(v, WORD_RST);
    rdr(OFS_WINDOW, v);
    chk(v, WORD_RST);
    rdr(OFS_STATUS, v);
    chk(v, 16'h0000);
    chk({15'h0, ENABLE_O}, 16'h0000);
    done("reset again");
    results();
  end
endmodule : tb_top
